// >>> pss_pkg.sv
// Constants, state codes and carrier types of the supply supervisor and sequencer.
// Assumes a single 20 MHz clock; all supervisory timing is counted in 1 ms ticks.
package pss_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timebase
  localparam int CLK_PERIOD_NS   = 50;
  localparam int TICK_MS         = 1;
  localparam int TICK_CYCLES_DEF = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  localparam int MS_W            = 14;
  typedef logic [MS_W-1:0] pss_ms_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Delays in milliseconds
  localparam pss_ms_type PG_HOLDUP_MS      = 14'h0004;
  localparam pss_ms_type SB_ON_MAX_MS      = 14'h05DC;
  localparam pss_ms_type ALL_ON_MAX_MS     = 14'h09C4;
  localparam pss_ms_type AC_MAIN_DELAY_MS  = 14'h0032;
  localparam pss_ms_type REQ_MAIN_DELAY_MS = 14'h0005;
  localparam pss_ms_type PG_ON_MIN_MS      = 14'h0064;
  localparam pss_ms_type PG_OFF_LEAD_MS    = 14'h0001;
  localparam pss_ms_type PG_LOW_MIN_MS     = 14'h0064;
  localparam pss_ms_type LATCH_AC_CLR_MS   = 14'h3A98;
  localparam pss_ms_type LATCH_REQ_CLR_MS  = 14'h03E8;
  localparam pss_ms_type OCP_QUAL_MS       = 14'h0014;
  localparam pss_ms_type OCW_QUAL_MS       = 14'h000A;
  localparam pss_ms_type SB_OCP_QUAL_MS    = 14'h0001;
  localparam pss_ms_type SB_HICCUP_MS      = 14'h0064;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and fields
  localparam int          REG_CTRL_OFF   = 32'h0000_0000;
  localparam int          REG_STATUS_OFF = 32'h0000_0004;
  localparam int          REG_ADDR_OFF   = 32'h0000_0008;
  localparam int          REG_FAULT_OFF  = 32'h0000_000C;
  localparam int          CTRL_INHIBIT_BIT = 0;
  localparam logic        CTRL_INHIBIT_RST = 1'h0;
  localparam logic [7:0]  IDENT_BASE     = 8'hA0;
  localparam logic [7:0]  MGMT_BASE      = 8'hB0;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  typedef enum logic [7:0] {
    ST_OFF       = 8'h01,
    ST_SB_START  = 8'h02,
    ST_MAIN_WAIT = 8'h04,
    ST_MAIN_RAMP = 8'h08,
    ST_PG_DELAY  = 8'h10,
    ST_RUN       = 8'h20,
    ST_HOLDUP    = 8'h40,
    ST_PG_DROP   = 8'h80
  } pss_state_type;

  ////////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic input_present;
    logic standby_in_reg;
    logic main_in_reg;
    logic main_current_limit;
  } pss_sense_type;

  typedef struct packed {
    logic main_overcurrent_trip;
    logic main_overcurrent_warning;
    logic standby_overcurrent_trip;
    logic overvoltage_trip;
    logic standby_overvoltage;
    logic short_circuit_trip;
    logic standby_short;
    logic overtemp_trip;
    logic overtemp_restore;
    logic overpower_warning;
    logic overpower_trip;
    logic temp_warning;
    logic general_failure;
    logic undervoltage;
    logic fan_fail;
  } pss_fault_type;

  typedef struct packed {
    logic [13:0] unused;
    logic        startup_fault;
    logic        alert_line;
    logic        alert;
    logic        sb_off;
    logic        thermal_off;
    logic        main_latched;
    logic        power_good;
    logic        main_enable;
    logic        standby_enable;
    logic        input_good;
    logic [7:0]  state;
  } pss_status_type;

endpackage : pss_pkg

// >>> pss_sequencer.sv
// Supervisor and output sequencer of a redundant front-end supply, APB register slave.
// Assumes all inputs synchronous to pclk; analog comparators deliver the fault and sense flags.
`timescale 1ns/1ps

module pss_sequencer
  import pss_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int ADDR_W      = 12
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Host pins
  input  wire logic          remote_on_request_n,
  input  wire logic          address_strap_low,
  input  wire logic          address_strap_high,
  output logic               power_good,
  output logic               input_good,
  input  wire logic          alert_n_i,
  output logic               alert_n_o,
  output logic               alert_n_oe_n,
  // Converter sense and control
  input  wire pss_sense_type sense,
  input  wire pss_fault_type faults,
  output logic               standby_output_enable,
  output logic               main_output_enable,
  output logic      [7:0]    identity_store_addr,
  output logic      [7:0]    management_endpoint_addr
);

  localparam int TICK_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  function automatic pss_ms_type ms_step(input pss_ms_type v, input logic run, input logic clr);
    if (clr) ms_step = '0;
    else if (run && (v != '1)) ms_step = v + 1'b1;
    else ms_step = v;
  endfunction : ms_step

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  logic [TICK_W-1:0] tick_cnt_q;
  wire               tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_cnt_q <= '0;
    else tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Protection state
  pss_state_type state_q, state_d;
  pss_ms_type    state_ms_q, pg_low_ms_q, ocp_ms_q, ocw_ms_q, sbo_ms_q;
  pss_ms_type    sb_off_ms_q, req_off_ms_q, ac_off_ms_q, ac_on_ms_q;
  logic          main_latched_q, thermal_off_q, sb_off_q, ctrl_inhibit_q;
  logic          from_ac_q, from_ac_d, hold_restart, startup_fault_q;
  logic          power_good_q, main_en_q, sb_en_q, input_good_q, alert_oe_n_q;

  wire on_req       = ~remote_on_request_n;
  wire main_prot_ok = on_req & ~main_latched_q & ~thermal_off_q & ~faults.overpower_trip & ~ctrl_inhibit_q;
  wire main_allowed = main_prot_ok & sense.input_present;
  // Current limit blocks the power-good delay but does not by itself drop a running rail
  wire outputs_ok   = sense.main_in_reg & sense.standby_in_reg & ~sense.main_current_limit;

  wire ocp_qual     = ocp_ms_q > OCP_QUAL_MS;
  wire ocw_qual     = ocw_ms_q > OCW_QUAL_MS;
  wire sbo_qual     = sbo_ms_q > SB_OCP_QUAL_MS;
  wire latch_set    = ocp_qual | faults.overvoltage_trip | faults.short_circuit_trip;
  wire latch_clr    = (req_off_ms_q >= LATCH_REQ_CLR_MS) | (ac_off_ms_q >= LATCH_AC_CLR_MS);
  wire sb_fault     = sbo_qual | faults.standby_overvoltage | faults.standby_short;
  wire sb_recover   = (sb_off_ms_q > SB_HICCUP_MS) & ~faults.standby_overvoltage & ~faults.standby_short;
  wire sb_off_d     = sb_fault | (sb_off_q & ~sb_recover);
  wire main_latched_d = latch_set | (main_latched_q & ~latch_clr); // set wins
  wire thermal_off_d  = faults.overtemp_trip | (thermal_off_q & ~faults.overtemp_restore);

  wire pss_ms_type main_delay = from_ac_q ? AC_MAIN_DELAY_MS : REQ_MAIN_DELAY_MS;
  wire state_restart = (state_d != state_q) | hold_restart;

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d      = state_q;
    from_ac_d    = from_ac_q;
    hold_restart = 1'b0;
    unique case (state_q)
      ST_OFF: begin
        if (sense.input_present) begin
          state_d   = ST_SB_START;
          from_ac_d = 1'b1;
        end
      end
      ST_SB_START: begin
        if (!sense.input_present) state_d = ST_OFF;
        else if (sense.standby_in_reg) state_d = ST_MAIN_WAIT;
      end
      ST_MAIN_WAIT: begin
        hold_restart = ~main_allowed;
        if (!main_allowed) from_ac_d = 1'b0;
        if (!sense.input_present) state_d = ST_OFF;
        else if (main_allowed && (state_ms_q > main_delay)) state_d = ST_MAIN_RAMP;
      end
      ST_MAIN_RAMP: begin
        if (!main_allowed) state_d = ST_PG_DROP;
        else if (outputs_ok) state_d = ST_PG_DELAY;
      end
      ST_PG_DELAY: begin
        hold_restart = ~outputs_ok;
        if (!main_allowed) state_d = ST_PG_DROP;
        else if (outputs_ok && (state_ms_q > PG_ON_MIN_MS) && (pg_low_ms_q > PG_LOW_MIN_MS)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        // Withdrawal and trips win over ride-through, so power-good never outlives them
        if (!main_prot_ok || !sense.main_in_reg || !sense.standby_in_reg) state_d = ST_PG_DROP;
        else if (!sense.input_present) state_d = ST_HOLDUP;
      end
      ST_HOLDUP: begin
        // Ride-through: the rail is still good, so power-good is held for the hold-up time
        if (!main_prot_ok || !sense.main_in_reg || (state_ms_q > PG_HOLDUP_MS)) state_d = ST_PG_DROP;
        else if (sense.input_present) state_d = ST_RUN;
      end
      ST_PG_DROP: begin
        if (state_ms_q > PG_OFF_LEAD_MS) state_d = sense.input_present ? ST_MAIN_WAIT : ST_OFF;
      end
      default: state_d = ST_OFF;
    endcase
    if ((state_d == ST_PG_DELAY) || (state_d == ST_PG_DROP)) from_ac_d = 1'b0;
  end

  wire pg_d      = (state_d == ST_RUN) | (state_d == ST_HOLDUP);
  wire main_en_d = (state_d != ST_OFF) & (state_d != ST_SB_START) & (state_d != ST_MAIN_WAIT);
  wire sb_en_d   = (state_d != ST_OFF) & ~sb_off_d;
  wire startup_fault_d = ((state_q == ST_SB_START) & (ac_on_ms_q >= SB_ON_MAX_MS))
                       | ((state_q == ST_MAIN_RAMP) & from_ac_q & (ac_on_ms_q >= ALL_ON_MAX_MS))
                       | (startup_fault_q & sense.input_present);
  wire alert_d   = faults.temp_warning | faults.general_failure | faults.undervoltage | faults.fan_fail
                 | faults.overvoltage_trip | faults.standby_overvoltage | ocw_qual
                 | faults.overpower_warning | faults.overpower_trip
                 | ~sense.input_present
                 | main_latched_q | thermal_off_q | sb_off_q | startup_fault_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q         <= ST_OFF;
      from_ac_q       <= 1'b0;
      main_latched_q  <= 1'b0;
      thermal_off_q   <= 1'b0;
      sb_off_q        <= 1'b0;
      startup_fault_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      from_ac_q       <= from_ac_d;
      main_latched_q  <= main_latched_d;
      thermal_off_q   <= thermal_off_d;
      sb_off_q        <= sb_off_d;
      startup_fault_q <= startup_fault_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good_q <= 1'b0;
      main_en_q    <= 1'b0;
      sb_en_q      <= 1'b0;
      input_good_q <= 1'b0;
      alert_oe_n_q <= 1'b1;
    end else begin
      power_good_q <= pg_d;
      main_en_q    <= main_en_d;
      sb_en_q      <= sb_en_d;
      input_good_q <= sense.input_present;
      alert_oe_n_q <= ~alert_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Millisecond timers, each cleared when its qualifying condition drops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ms_q   <= '0;
      pg_low_ms_q  <= '0;
      ocp_ms_q     <= '0;
      ocw_ms_q     <= '0;
      sbo_ms_q     <= '0;
      sb_off_ms_q  <= '0;
      req_off_ms_q <= '0;
      ac_off_ms_q  <= '0;
      ac_on_ms_q   <= '0;
    end else begin
      state_ms_q   <= ms_step(state_ms_q, tick, state_restart);
      pg_low_ms_q  <= ms_step(pg_low_ms_q, tick, pg_d);
      ocp_ms_q     <= ms_step(ocp_ms_q, tick, ~faults.main_overcurrent_trip);
      ocw_ms_q     <= ms_step(ocw_ms_q, tick, ~faults.main_overcurrent_warning);
      sbo_ms_q     <= ms_step(sbo_ms_q, tick, ~faults.standby_overcurrent_trip);
      sb_off_ms_q  <= ms_step(sb_off_ms_q, tick, ~sb_off_q);
      req_off_ms_q <= ms_step(req_off_ms_q, tick, ~remote_on_request_n);
      ac_off_ms_q  <= ms_step(ac_off_ms_q, tick, sense.input_present);
      ac_on_ms_q   <= ms_step(ac_on_ms_q, tick, ~sense.input_present);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address straps, caught once after reset release so a moving strap cannot shift the address
  logic       strap_done_q;
  wire  [7:0] strap_offset = {5'h00, address_strap_high, address_strap_low, 1'h0};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_done_q             <= 1'b0;
      identity_store_addr      <= IDENT_BASE;
      management_endpoint_addr <= MGMT_BASE;
    end else if (!strap_done_q) begin
      strap_done_q             <= 1'b1;
      identity_store_addr      <= IDENT_BASE + strap_offset;
      management_endpoint_addr <= MGMT_BASE + strap_offset;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states; read data captured in the setup cycle
  pss_status_type status_word;
  logic [31:0]    prdata_q;

  wire apb_setup  = psel & ~penable;
  wire apb_access = psel & penable;
  wire sel_ctrl   = (paddr == ADDR_W'(REG_CTRL_OFF));
  wire sel_status = (paddr == ADDR_W'(REG_STATUS_OFF));
  wire sel_addr   = (paddr == ADDR_W'(REG_ADDR_OFF));
  wire sel_fault  = (paddr == ADDR_W'(REG_FAULT_OFF));
  wire addr_hit   = sel_ctrl | sel_status | sel_addr | sel_fault;
  wire ctrl_wr    = apb_access & pwrite & sel_ctrl;
  wire [31:0] rd_word = sel_ctrl   ? {31'h0000_0000, ctrl_inhibit_q}
                      : sel_status ? status_word
                      : sel_addr   ? {16'h0000, management_endpoint_addr, identity_store_addr}
                      : sel_fault  ? {17'h0_0000, faults}
                      : 32'h0000_0000;

  assign status_word = '{unused: 14'h0000, startup_fault: startup_fault_q, alert_line: alert_n_i,
                         alert: ~alert_oe_n_q, sb_off: sb_off_q, thermal_off: thermal_off_q,
                         main_latched: main_latched_q, power_good: power_good_q, main_enable: main_en_q,
                         standby_enable: sb_en_q, input_good: input_good_q, state: state_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q       <= 32'h0000_0000;
      ctrl_inhibit_q <= CTRL_INHIBIT_RST;
    end else begin
      if (apb_setup && !pwrite) prdata_q <= rd_word;
      if (ctrl_wr) ctrl_inhibit_q <= pwdata[CTRL_INHIBIT_BIT];
    end
  end

  assign prdata                = prdata_q;
  assign pready                = 1'b1;
  assign pslverr               = apb_access & ~addr_hit;
  assign power_good            = power_good_q;
  assign input_good            = input_good_q;
  assign main_output_enable    = main_en_q;
  assign standby_output_enable = sb_en_q;
  assign alert_n_o             = 1'b0;
  assign alert_n_oe_n          = alert_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  a_ingood_follows:
    assert property (@(posedge pclk) disable iff (!presetn) !sense.input_present |=> !input_good)
    else $error("input-good still high after input loss");

  a_holdup_time:
    assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_HOLDUP) && (state_d == ST_PG_DROP) && main_prot_ok && sense.main_in_reg
      |-> state_ms_q > PG_HOLDUP_MS)
    else $error("power-good dropped before hold-up time");

  a_ac_main_delay:
    assert property (@(posedge pclk) disable iff (!presetn)
      $rose(main_output_enable) && $past(from_ac_q) |-> $past(state_ms_q) > AC_MAIN_DELAY_MS)
    else $error("main enabled too early after standby");

  a_req_main_delay:
    assert property (@(posedge pclk) disable iff (!presetn)
      $rose(main_output_enable) |-> $past(state_ms_q) > REQ_MAIN_DELAY_MS)
    else $error("main enabled too early after on request");

  a_req_pg_drop:
    assert property (@(posedge pclk) disable iff (!presetn) power_good && remote_on_request_n |=> !power_good)
    else $error("power-good held after on request withdrawn");

  a_pg_on_delay:
    assert property (@(posedge pclk) disable iff (!presetn)
      $rose(power_good) |-> ($past(state_ms_q) > PG_ON_MIN_MS) && ($past(pg_low_ms_q) > PG_LOW_MIN_MS))
    else $error("power-good rose too early");

  a_pg_leads_main:
    assert property (@(posedge pclk) disable iff (!presetn)
      $fell(main_output_enable) |-> !power_good && (pg_low_ms_q > PG_OFF_LEAD_MS))
    else $error("main disabled too soon after power-good fell");

  a_latch_clear:
    assert property (@(posedge pclk) disable iff (!presetn)
      main_latched_q && (req_off_ms_q >= LATCH_REQ_CLR_MS) && !latch_set |=> !main_latched_q)
    else $error("latch not cleared by on request off time");

  a_ocp_latch:
    assert property (@(posedge pclk) disable iff (!presetn) ocp_qual |=> main_latched_q ##1 !power_good)
    else $error("overcurrent did not latch main off");

  a_ocw_alert:
    assert property (@(posedge pclk) disable iff (!presetn) ocw_qual |=> !alert_n_oe_n)
    else $error("overcurrent warning did not raise alert");

  a_sb_hiccup:
    assert property (@(posedge pclk) disable iff (!presetn) sbo_qual |=> !standby_output_enable)
    else $error("standby not shut on overcurrent");

  a_thermal_off:
    assert property (@(posedge pclk) disable iff (!presetn) thermal_off_q |=> !power_good)
    else $error("power-good high during overtemperature");

  // The release edge itself still runs the reset branch, so it may not start an attempt
  a_input_alert:
    assert property (@(posedge pclk) disable iff (!presetn) presetn && !sense.input_present |=> !alert_n_oe_n)
    else $error("alert not raised on input loss");

  a_short_latch:
    assert property (@(posedge pclk) disable iff (!presetn) faults.short_circuit_trip |=> main_latched_q)
    else $error("main short did not latch main off");

  a_sb_kept_on_trip:
    assert property (@(posedge pclk) disable iff (!presetn)
      latch_set && !sb_fault && !sb_off_q && (state_q != ST_OFF) && sense.input_present
      |=> standby_output_enable)
    else $error("standby dropped on a main trip");

  a_pg_needs_rails:
    assert property (@(posedge pclk) disable iff (!presetn)
      $rose(power_good) |-> $past(sense.main_in_reg) && $past(sense.standby_in_reg)
                            && !$past(sense.main_current_limit))
    else $error("power-good rose without regulated rails");

  a_temp_alert:
    assert property (@(posedge pclk) disable iff (!presetn) faults.temp_warning |=> !alert_n_oe_n)
    else $error("temperature warning did not raise alert");

endmodule : pss_sequencer

// >>> pss_rail_model.sv
// Rail model behind the sequencer: enables in, regulation flags out.
// Assumes one clock; rails settle RISE cycles after enable.
`timescale 1ns/1ps
module pss_rail_model
  import pss_pkg::*;
#(parameter int RISE = 6) (
  // Clock, reset, mains
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic input_present,
  // Enables
  input  wire logic standby_output_enable,
  input  wire logic main_output_enable,
  // Load
  input  wire logic main_current_limit,
  // Flags
  output pss_sense_type sense
);
  int sb_q;
  int mn_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_q <= 0;
      mn_q <= 0;
    end else begin
      sb_q <= standby_output_enable ? sb_q + int'(sb_q < RISE) : 0;
      mn_q <= main_output_enable ? mn_q + int'(mn_q < RISE) : 0;
    end
  end
  // Rails drop at once on disable: the harsh case for the power-good lead
  assign sense = '{input_present, sb_q == RISE, mn_q == RISE, main_current_limit};
endmodule : pss_rail_model

// >>> testbench.sv
// Self-checking bench of the sequencer: APB, straps, sequencing, faults.
// Assumes the rail model closes the loop from enables to regulation.
`timescale 1ns/1ps
module testbench;
  import pss_pkg::*;
  localparam int T = 4;  // Cycles per ms, keeps the run short
  logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]   paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd;
  logic          pready, pslverr, err, alert_o, alert_oe_n, power_good, input_good, sb_en, mn_en;
  logic          req_n = 1, strap_lo = 0, strap_hi = 0, ac = 0, climit = 0;
  logic [7:0]    id_addr, mg_addr;
  pss_sense_type sense;
  pss_fault_type faults = '0;
  int            mismatches = 0, n_tests = 0, cyc = 0, ta, t0, t1, t2;
  // Open-drain alert line with its board pull-up
  wire           alert_line = alert_oe_n ? 1'b1 : alert_o;
  wire [6:0]     obs = {sense.main_in_reg, sense.standby_in_reg, power_good, input_good, mn_en, sb_en, alert_oe_n};
  always #25 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  pss_sequencer #(.TICK_CYCLES(T), .ADDR_W(12)) i_pss_sequencer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .remote_on_request_n(req_n), .address_strap_low(strap_lo), .address_strap_high(strap_hi),
    .power_good(power_good), .input_good(input_good), .alert_n_i(alert_line), .alert_n_o(alert_o),
    .alert_n_oe_n(alert_oe_n), .sense(sense), .faults(faults), .standby_output_enable(sb_en),
    .main_output_enable(mn_en), .identity_store_addr(id_addr), .management_endpoint_addr(mg_addr));
  pss_rail_model i_pss_rail_model (.pclk(pclk), .presetn(presetn), .input_present(ac),
    .standby_output_enable(sb_en), .main_output_enable(mn_en), .main_current_limit(climit), .sense(sense));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_val(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task automatic check_range(string nm, int lo, int hi, int g);
    n_tests++;
    if (g < lo || g > hi) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : check_range
  // Bounded wait; a timeout returns after 3000*T cycles, which a range ending at 3000*T still accepts
  task automatic wait_bit(int k, logic v, output int t);
    for (int n = 0; n < 3000 * T && obs[k] !== v; n++) @(posedge pclk);
    t = cyc;
  endtask : wait_bit
  task automatic apb(logic wr, int a, logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= 12'(a);
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic do_reset(logic hi, logic lo);
    presetn <= 0;
    strap_hi <= hi;
    strap_lo <= lo;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_straps;
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1], i[0]);
      apb(0, REG_ADDR_OFF, '0);
      check_val("addr", {16'h0, MGMT_BASE + 8'(2 * i), IDENT_BASE + 8'(2 * i)}, rd);
      check_val("pins", {16'h0, MGMT_BASE + 8'(2 * i), IDENT_BASE + 8'(2 * i)}, {16'h0, mg_addr, id_addr});
      check_val("off", 32'h0, {sb_en, mn_en, power_good, input_good});
    end
    apb(1, REG_CTRL_OFF, 32'h1);
    apb(0, REG_CTRL_OFF, '0);
    check_val("ctrl", 32'h1, rd & 32'h1);
    apb(1, REG_CTRL_OFF, '0);
    apb(0, 32'h10, '0);
    check_val("unmapped", 32'h1, {31'h0, err});
  endtask : t_straps
  task automatic t_ac_on;
    ac <= 1;
    req_n <= 0;
    ta = cyc;
    wait_bit(5, 1, t0);
    check_range("sb_on", 0, 1500 * T, t0 - ta);
    wait_bit(6, 1, t1);
    check_range("sb_main", 50 * T, 2000 * T, t1 - t0);
    check_range("all_on", 0, 2500 * T, t1 - ta);
    wait_bit(4, 1, t2);
    check_range("pg_on", 100 * T, 500 * T, t2 - t1);
    check_val("ig", 32'h1, {31'h0, input_good});
  endtask : t_ac_on
  task automatic t_req;
    req_n <= 1;
    ta = cyc;
    wait_bit(4, 0, t0);
    check_range("pg_off", 0, 5 * T, t0 - ta);
    wait_bit(6, 0, t1);
    check_range("pg_lead", T, 3000 * T, t1 - t0);
    check_val("sb_kept", 32'h1, {31'h0, sb_en});
    req_n <= 0;
    ta = cyc;
    wait_bit(6, 1, t1);
    check_range("req_on", 5 * T, 400 * T, t1 - ta);
    climit <= 1;
    repeat (150 * T) @(posedge pclk);
    check_val("pg_climit", 32'h0, {31'h0, power_good});
    climit <= 0;
    ta = cyc;
    wait_bit(4, 1, t2);
    check_range("pg_low", 100 * T, 3000 * T, t2 - t0);
    check_range("pg_restart", 100 * T, 500 * T, t2 - ta);
  endtask : t_req
  task automatic t_ac_loss;
    ac <= 0;
    ta = cyc;
    wait_bit(3, 0, t0);
    check_range("ig_off", 0, 4 * T, t0 - ta);
    wait_bit(0, 0, t1);
    check_range("alert_ac", 0, 4 * T, t1 - ta);
    wait_bit(4, 0, t2);
    check_range("holdup", 4 * T, 3000 * T, t2 - ta);
    check_range("ig_lead", T, 3000 * T, t2 - t0);
    wait_bit(5, 0, t2);
  endtask : t_ac_loss
  task automatic t_faults;
    t_ac_on();
    faults.main_overcurrent_warning <= 1;
    ta = cyc;
    wait_bit(0, 0, t0);
    check_range("ocw", 10 * T, 15 * T, t0 - ta);
    check_val("ocw_run", 32'h1, {31'h0, mn_en});
    faults <= '0;
    wait_bit(0, 1, t0);
    faults.overvoltage_trip <= 1;
    wait_bit(2, 0, t0);
    faults <= '0;
    apb(0, REG_STATUS_OFF, '0);
    check_val("latch", 32'h9200, rd & 32'h1FE00);
    repeat (200 * T) @(posedge pclk);
    check_val("held", 32'h0, {31'h0, mn_en});
    req_n <= 1;
    repeat (1002 * T) @(posedge pclk);
    req_n <= 0;
    ta = cyc;
    wait_bit(6, 1, t1);
    check_range("unlatch", 5 * T, 400 * T, t1 - ta);
  endtask : t_faults
  task automatic t_protect;
    faults.temp_warning <= 1;
    wait_bit(0, 0, t0);
    check_val("tw_run", 32'h1, {31'h0, mn_en});
    faults <= '0;
    wait_bit(0, 1, t0);
    faults.overpower_warning <= 1;
    wait_bit(0, 0, t0);
    check_val("opw_run", 32'h1, {31'h0, mn_en});
    faults <= '0;
    faults.standby_overcurrent_trip <= 1;
    ta = cyc;
    wait_bit(1, 0, t0);
    check_range("sb_ocp", T, 100 * T, t0 - ta);
    faults <= '0;
    wait_bit(1, 1, t1);
    check_range("sb_retry", 100 * T, 3000 * T, t1 - t0);
    wait_bit(4, 1, t2);
    faults.overtemp_trip <= 1;
    wait_bit(2, 0, t0);
    faults <= '0;
    repeat (20 * T) @(posedge pclk);
    check_val("ot_hold", 32'h1, {30'h0, mn_en, sb_en});
    faults.overtemp_restore <= 1;
    ta = cyc;
    wait_bit(2, 1, t1);
    check_range("ot_back", 5 * T, 400 * T, t1 - ta);
    faults <= '0;
    faults.main_overcurrent_trip <= 1;
    ta = cyc;
    wait_bit(2, 0, t0);
    check_range("ocp", 20 * T, 200 * T, t0 - ta);
    faults <= '0;
    req_n <= 1;
    repeat (1002 * T) @(posedge pclk);
    req_n <= 0;
    ta = cyc;
    wait_bit(2, 1, t1);
    check_range("ocp_clr", 5 * T, 400 * T, t1 - ta);
    faults.short_circuit_trip <= 1;
    wait_bit(2, 0, t0);
    check_val("scp_sb", 32'h1, {31'h0, sb_en});
    faults <= '0;
    repeat (50 * T) @(posedge pclk);
    check_val("scp_held", 32'h0, {31'h0, mn_en});
  endtask : t_protect
  task automatic finish_test;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial begin
    t_straps();
    t_ac_on();
    t_req();
    t_ac_loss();
    t_faults();
    t_protect();
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    mismatches++;
    finish_test();
  end
endmodule : testbench
